// ### design/scsi_conv_pkg.sv
// Shared constants and types for the differential SCSI control converter
package scsi_conv_pkg;

    // The nine SCSI control signals, one bit each in every control vector
    localparam int unsigned NUM_SIG = 9;
    localparam int unsigned SIG_ACK = 0;
    localparam int unsigned SIG_ATN = 1;
    localparam int unsigned SIG_BSY = 2;
    localparam int unsigned SIG_CD  = 3;
    localparam int unsigned SIG_IO  = 4;
    localparam int unsigned SIG_MSG = 5;
    localparam int unsigned SIG_REQ = 6;
    localparam int unsigned SIG_RST = 7;
    localparam int unsigned SIG_SEL = 8;

    // Values after reset
    localparam logic [8:0] CTRL_RELEASED = 9'h1ff;
    localparam logic [8:0] NONE_DRIVEN   = 9'h000;
    localparam logic       DRIVE_RESET   = 1'b0;
    localparam logic       DIR_RESET     = 1'b0;

    // Cycles for our own drive to leave the loopback path: output flop plus two sync stages
    localparam int unsigned SETTLE_CYCLES = 3;
    localparam logic [1:0]  SETTLE_LOAD   = 2'(SETTLE_CYCLES);

    // Who currently sources one control signal
    typedef enum logic [1:0] {
        OWN_NONE,
        OWN_CTRL,
        OWN_CABLE
    } owner_t;

    // Decoded bus phase, stepped on the crystal reference
    typedef enum logic [2:0] {
        PH_BUS_FREE,
        PH_ARBITRATION,
        PH_ARB_TIMED_OUT,
        PH_SELECTION,
        PH_INFO
    } phase_t;

endpackage

// ### design/scsi_diff_control_converter.sv
// Control-signal converter between a single-ended SCSI controller and a differential cable
`timescale 1ns/1ps

module scsi_diff_control_converter (
    // Clock and reset
    input  wire logic       CLK_SYS,
    input  wire logic       RST_N,
    // Reset, sense and test inputs
    input  wire logic       DIFF_SENSE_N,
    input  wire logic       FILTERED_BUS_RESET_IN_N,
    input  wire logic       TEST_MODE_IN,
    // Crystal reference
    input  wire logic       CRYSTAL_CLOCK_IN,
    output logic            CRYSTAL_FEEDBACK_OUT,
    // Arbitration timeout network
    input  wire logic       TIMEOUT_RC_EXPIRED,
    output logic            TIMEOUT_DISCHARGE,
    // Controller side, active low, one bit per control signal
    input  wire logic [8:0] CTRL_SIG_IN_N,
    output logic      [8:0] CTRL_SIG_OUT_N,
    output logic      [8:0] CTRL_SIG_OE,
    // Cable side, differential pairs seen as active-high levels
    input  wire logic [8:0] CABLE_SIG_IN,
    output logic      [8:0] CABLE_SIG_OUT,
    output logic      [8:0] CABLE_SIG_OE,
    // Companion data transceiver control
    output logic            INFO_PHASE_DRIVE_OUT,
    output logic            DIFF_TO_SE_DIRECTION_OUT
);

    // Two-stage synchronisers; only stage two is read by logic
    logic [8:0] ctrl_meta_reg;
    logic [8:0] ctrl_sync_reg;
    logic [8:0] cable_meta_reg;
    logic [8:0] cable_sync_reg;
    logic [4:0] misc_meta_reg;
    logic [4:0] misc_sync_reg;
    logic       xtal_prev_reg;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ctrl_meta_reg  <= scsi_conv_pkg::CTRL_RELEASED;
            ctrl_sync_reg  <= scsi_conv_pkg::CTRL_RELEASED;
            cable_meta_reg <= scsi_conv_pkg::NONE_DRIVEN;
            cable_sync_reg <= scsi_conv_pkg::NONE_DRIVEN;
            misc_meta_reg  <= 5'h03;
            misc_sync_reg  <= 5'h03;
            xtal_prev_reg  <= 1'b0;
        end else begin
            ctrl_meta_reg  <= CTRL_SIG_IN_N;
            ctrl_sync_reg  <= ctrl_meta_reg;
            cable_meta_reg <= CABLE_SIG_IN;
            cable_sync_reg <= cable_meta_reg;
            misc_meta_reg  <= {CRYSTAL_CLOCK_IN, TIMEOUT_RC_EXPIRED, TEST_MODE_IN,
                               FILTERED_BUS_RESET_IN_N, DIFF_SENSE_N};
            misc_sync_reg  <= misc_meta_reg;
            xtal_prev_reg  <= misc_sync_reg[4];
        end
    end

    // Named views of the synchronised inputs
    wire        sense_ok    = misc_sync_reg[0];
    wire        bus_reset   = ~misc_sync_reg[1];
    wire        test_mode   = misc_sync_reg[2];
    wire        rc_expired  = misc_sync_reg[3];
    wire        xtal_level  = misc_sync_reg[4];
    wire        ref_tick    = xtal_level & ~xtal_prev_reg;
    wire        hard_kill   = ~sense_ok;
    wire        soft_kill   = hard_kill | bus_reset;
    wire [8:0]  ctrl_act    = ~ctrl_sync_reg;
    wire [8:0]  cable_act   = cable_sync_reg;
    wire [8:0]  bus_act     = ctrl_act | cable_act;

    // Per-signal ownership: whichever side asserts first is copied to the other
    scsi_conv_pkg::owner_t owner_reg  [9];
    scsi_conv_pkg::owner_t owner_next [9];
    logic [1:0]            quiet_reg  [9];
    logic [1:0]            quiet_next [9];
    logic [8:0]            ctrl_owned;
    logic [8:0]            ctrl_drv_next;
    logic [8:0]            cable_drv_next;
    logic [8:0]            cable_oe_next;

    genvar g;
    generate
        for (g = 0; g < 9; g++) begin : g_sig
            // The reset line keeps passing through a filtered bus reset
            wire kill = (g == scsi_conv_pkg::SIG_RST) ? hard_kill : soft_kill;
            wire idle = (owner_reg[g] == scsi_conv_pkg::OWN_NONE);
            wire held = (owner_reg[g] == scsi_conv_pkg::OWN_CTRL)  ? ctrl_act[g] :
                        (owner_reg[g] == scsi_conv_pkg::OWN_CABLE) ? cable_act[g] : 1'b0;
            wire quiet = (quiet_reg[g] == 2'h0);

            // The settle gap stops our own echo from being taken as the far side asserting
            assign owner_next[g] =
                (kill || test_mode)          ? scsi_conv_pkg::OWN_NONE :
                (!idle && held)              ? owner_reg[g] :
                (!idle)                      ? scsi_conv_pkg::OWN_NONE :
                (quiet && ctrl_act[g])       ? scsi_conv_pkg::OWN_CTRL :
                (quiet && cable_act[g])      ? scsi_conv_pkg::OWN_CABLE :
                                               scsi_conv_pkg::OWN_NONE;

            assign quiet_next[g] =
                (!idle && owner_next[g] == scsi_conv_pkg::OWN_NONE) ? scsi_conv_pkg::SETTLE_LOAD :
                (!quiet)                                             ? quiet_reg[g] - 2'h1 :
                                                                       2'h0;

            assign ctrl_owned[g]     = (owner_reg[g] == scsi_conv_pkg::OWN_CTRL);
            assign ctrl_drv_next[g]  = (owner_next[g] == scsi_conv_pkg::OWN_CABLE);
            // Test mode copies the controller side straight onto the cable
            assign cable_drv_next[g] = test_mode ? (ctrl_act[g] & ~hard_kill) :
                                       (owner_next[g] == scsi_conv_pkg::OWN_CTRL);
            assign cable_oe_next[g]  = test_mode ? ~hard_kill :
                                       (owner_next[g] == scsi_conv_pkg::OWN_CTRL);

            always_ff @(posedge CLK_SYS) begin
                if (!RST_N) begin
                    owner_reg[g] <= scsi_conv_pkg::OWN_NONE;
                    quiet_reg[g] <= 2'h0;
                end else begin
                    owner_reg[g] <= owner_next[g];
                    quiet_reg[g] <= quiet_next[g];
                end
            end
        end
    endgenerate

    // Phase decoding, stepped once per rising crystal reference edge
    scsi_conv_pkg::phase_t phase_reg;
    scsi_conv_pkg::phase_t phase_step;
    scsi_conv_pkg::phase_t phase_next;

    wire bsy     = bus_act[scsi_conv_pkg::SIG_BSY];
    wire sel     = bus_act[scsi_conv_pkg::SIG_SEL];
    wire free    = ~bsy & ~sel;

    always_comb begin
        phase_step = phase_reg;
        unique case (phase_reg)
            scsi_conv_pkg::PH_BUS_FREE: begin
                if (sel)
                    phase_step = scsi_conv_pkg::PH_SELECTION;
                else if (bsy)
                    phase_step = scsi_conv_pkg::PH_ARBITRATION;
            end
            scsi_conv_pkg::PH_ARBITRATION: begin
                if (sel)
                    phase_step = scsi_conv_pkg::PH_SELECTION;
                else if (free)
                    phase_step = scsi_conv_pkg::PH_BUS_FREE;
                else if (rc_expired)
                    phase_step = scsi_conv_pkg::PH_ARB_TIMED_OUT;
            end
            scsi_conv_pkg::PH_ARB_TIMED_OUT: begin
                // Wait for the bus to go free before arbitrating again
                if (free)
                    phase_step = scsi_conv_pkg::PH_BUS_FREE;
            end
            scsi_conv_pkg::PH_SELECTION: begin
                if (free)
                    phase_step = scsi_conv_pkg::PH_BUS_FREE;
                else if (!sel && bsy)
                    phase_step = scsi_conv_pkg::PH_INFO;
            end
            scsi_conv_pkg::PH_INFO: begin
                if (!bsy)
                    phase_step = scsi_conv_pkg::PH_BUS_FREE;
                else if (sel)
                    phase_step = scsi_conv_pkg::PH_SELECTION;
            end
        endcase
    end

    assign phase_next = soft_kill ? scsi_conv_pkg::PH_BUS_FREE :
                        ref_tick  ? phase_step : phase_reg;

    // Data direction: in an information phase the target drives when I/O is asserted;
    // outside one, the controller only sources data while it arbitrates or selects
    wire io_act    = bus_act[scsi_conv_pkg::SIG_IO];
    wire io_local  = ctrl_owned[scsi_conv_pkg::SIG_IO];
    wire ctrl_ids  = ctrl_owned[scsi_conv_pkg::SIG_BSY] | ctrl_owned[scsi_conv_pkg::SIG_SEL];
    wire info_next = (phase_next == scsi_conv_pkg::PH_INFO);
    wire drive_next = ~soft_kill & info_next;
    wire dir_next   = ~soft_kill & (info_next ? (io_act ^ io_local)
                                              : ~ctrl_ids);
    wire disch_next = (phase_next != scsi_conv_pkg::PH_ARBITRATION);

    // Output flops
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            phase_reg                <= scsi_conv_pkg::PH_BUS_FREE;
            CTRL_SIG_OUT_N           <= scsi_conv_pkg::CTRL_RELEASED;
            CTRL_SIG_OE              <= scsi_conv_pkg::NONE_DRIVEN;
            CABLE_SIG_OUT            <= scsi_conv_pkg::NONE_DRIVEN;
            CABLE_SIG_OE             <= scsi_conv_pkg::NONE_DRIVEN;
            INFO_PHASE_DRIVE_OUT     <= scsi_conv_pkg::DRIVE_RESET;
            DIFF_TO_SE_DIRECTION_OUT <= scsi_conv_pkg::DIR_RESET;
            TIMEOUT_DISCHARGE        <= 1'b1;
            CRYSTAL_FEEDBACK_OUT     <= 1'b1;
        end else begin
            phase_reg                <= phase_next;
            CTRL_SIG_OUT_N           <= ~ctrl_drv_next;
            CTRL_SIG_OE              <= ctrl_drv_next;
            CABLE_SIG_OUT            <= cable_drv_next;
            CABLE_SIG_OE             <= cable_oe_next;
            INFO_PHASE_DRIVE_OUT     <= drive_next;
            DIFF_TO_SE_DIRECTION_OUT <= dir_next;
            TIMEOUT_DISCHARGE        <= disch_next;
            CRYSTAL_FEEDBACK_OUT     <= ~xtal_level;
        end
    end

endmodule

// ### tb/scsi_conv_checker.sv
// Port-level assertions for the control converter
`timescale 1ns/1ps
module scsi_conv_checker (
    input wire logic       CLK_SYS,
    input wire logic       RST_N,
    input wire logic       DIFF_SENSE_N,
    input wire logic       FILTERED_BUS_RESET_IN_N,
    input wire logic       TEST_MODE_IN,
    input wire logic       TIMEOUT_RC_EXPIRED,
    input wire logic       TIMEOUT_DISCHARGE,
    input wire logic [8:0] CTRL_SIG_IN_N,
    input wire logic [8:0] CTRL_SIG_OUT_N,
    input wire logic [8:0] CTRL_SIG_OE,
    input wire logic [8:0] CABLE_SIG_IN,
    input wire logic [8:0] CABLE_SIG_OUT,
    input wire logic [8:0] CABLE_SIG_OE,
    input wire logic       INFO_PHASE_DRIVE_OUT,
    input wire logic       DIFF_TO_SE_DIRECTION_OUT
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    wire run_ok = DIFF_SENSE_N && FILTERED_BUS_RESET_IN_N && !TEST_MODE_IN;
    wire rst_ok = DIFF_SENSE_N && !TEST_MODE_IN;
    // Eight samples cover sync, output flop and a possible echo guard
    sequence ctrl_held(k, en);
        (en && !CTRL_SIG_IN_N[k] && !CTRL_SIG_OE[k])[*8];
    endsequence
    sequence cable_held(k, en);
        (en && CABLE_SIG_IN[k] && !CABLE_SIG_OE[k])[*8];
    endsequence
    sequence arb_expired;
        !TIMEOUT_DISCHARGE && TIMEOUT_RC_EXPIRED;
    endsequence
    AST_RESET_IDLE: assert property (disable iff (1'b0) !RST_N |=>
        CTRL_SIG_OE == 9'h000 && CABLE_SIG_OE == 9'h000 && CTRL_SIG_OUT_N == 9'h1ff && TIMEOUT_DISCHARGE
        && !INFO_PHASE_DRIVE_OUT && !DIFF_TO_SE_DIRECTION_OUT) else $error("outputs not idle in reset");
    AST_SENSE_KILL: assert property ((!DIFF_SENSE_N)[*4] |=>
        CTRL_SIG_OE == 9'h000 && CABLE_SIG_OE == 9'h000 && !INFO_PHASE_DRIVE_OUT) else $error("sense kill");
    AST_PASS_C2B: assert property (ctrl_held(6, run_ok) |->
        CABLE_SIG_OE[6] && CABLE_SIG_OUT[6]) else $error("controller bit not passed to cable");
    AST_PASS_B2C: assert property (cable_held(2, run_ok) |->
        CTRL_SIG_OE[2] && !CTRL_SIG_OUT_N[2]) else $error("cable bit not passed to controller");
    AST_BUSRST_PASS: assert property (cable_held(7, rst_ok) |->
        CTRL_SIG_OE[7] && !CTRL_SIG_OUT_N[7]) else $error("bus reset bit not passed");
    AST_RELEASE: assert property ((run_ok && CABLE_SIG_OE[0] && CTRL_SIG_IN_N[0])[*4] |=>
        !CABLE_SIG_OE[0]) else $error("cable drive kept after release");
    AST_TEST_MODE: assert property ((TEST_MODE_IN && DIFF_SENSE_N && FILTERED_BUS_RESET_IN_N)[*4] |=>
        CABLE_SIG_OE == 9'h1ff && CTRL_SIG_OE == 9'h000) else $error("test mode drivers");
    AST_ARB_TIMEOUT: assert property (arb_expired |-> ##[1:12] TIMEOUT_DISCHARGE)
        else $error("arbitration wait not ended");
endmodule

// ### tb/scsi_far_model.sv
// Controller, cable, crystal and RC network around the converter
`timescale 1ns/1ps
module scsi_far_model #(
    parameter int RC_CYCLES = 60
) (
    input  wire logic       clk,
    input  wire logic [8:0] ctrl_assert,
    input  wire logic [8:0] cable_assert,
    input  wire logic [8:0] ctrl_out_n,
    input  wire logic [8:0] ctrl_oe,
    input  wire logic [8:0] cable_out,
    input  wire logic [8:0] cable_oe,
    input  wire logic       discharge,
    output logic      [8:0] ctrl_line_n,
    output logic      [8:0] cable_line,
    output logic            bus_reset_n,
    output logic            xtal,
    output logic            rc_expired
);
    logic [7:0] rc_count_reg;
    // Released lines fall back to their pulls: controller high, cable deasserted
    assign ctrl_line_n = ~(ctrl_assert | (ctrl_oe & ~ctrl_out_n));
    assign cable_line  = cable_assert | (cable_oe & cable_out);
    assign rc_expired  = rc_count_reg >= 8'(RC_CYCLES);
    initial begin
        rc_count_reg = 8'h00;
        bus_reset_n = 1'b1;
        xtal = 1'b0;
        #2;
        forever #25 xtal = ~xtal;
    end
    always @(posedge clk) begin
        rc_count_reg <= discharge ? 8'h00 : rc_count_reg + {7'h00, ~rc_expired};
        bus_reset_n <= ~cable_line[7];
    end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the control converter
`timescale 1ns/1ps
module tb_top;
    logic       clk_sys = 1'b0, rst_n = 1'b0, sense_n = 1'b1, test_in = 1'b0;
    logic       filt_n, xtal, rc_exp, disch, drive, dir, xfb;
    logic [8:0] ca = 9'h000, ba = 9'h000, ctrl_in_n, cab_in, c_out_n, c_oe, b_out, b_oe, m;
    int         bad_count = 0, checks_done = 0, k;
    scsi_diff_control_converter dut_u (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .DIFF_SENSE_N(sense_n), .FILTERED_BUS_RESET_IN_N(filt_n),
        .TEST_MODE_IN(test_in), .CRYSTAL_CLOCK_IN(xtal), .CRYSTAL_FEEDBACK_OUT(xfb), .TIMEOUT_RC_EXPIRED(rc_exp),
        .TIMEOUT_DISCHARGE(disch), .CTRL_SIG_IN_N(ctrl_in_n), .CTRL_SIG_OUT_N(c_out_n), .CTRL_SIG_OE(c_oe),
        .CABLE_SIG_IN(cab_in), .CABLE_SIG_OUT(b_out), .CABLE_SIG_OE(b_oe), .INFO_PHASE_DRIVE_OUT(drive),
        .DIFF_TO_SE_DIRECTION_OUT(dir));
    scsi_far_model #(.RC_CYCLES(60)) far_u (.clk(clk_sys), .ctrl_assert(ca), .cable_assert(ba),
        .ctrl_out_n(c_out_n), .ctrl_oe(c_oe), .cable_out(b_out), .cable_oe(b_oe), .discharge(disch),
        .ctrl_line_n(ctrl_in_n), .cable_line(cab_in), .bus_reset_n(filt_n), .xtal(xtal), .rc_expired(rc_exp));
    initial forever #5 clk_sys = ~clk_sys;
    function automatic logic [8:0] bit_of(input int n);
        return 9'h001 << n;
    endfunction
    function automatic logic dir_exp(input logic io_on, input logic ctrl_owns);
        return io_on ^ ctrl_owns;
    endfunction
    // Wide enough for both nine-bit driver enables side by side
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Mode bits are sense_n then test_in; everything lands on a rising edge
    task automatic go(input logic [8:0] c, input logic [8:0] b, input logic [1:0] md, input int n);
        @(posedge clk_sys);
        ca <= c;
        ba <= b;
        {sense_n, test_in} <= md;
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #50000;
        bad_count++;
        end_sim();
    end
    initial begin
        k = $urandom(40);
        go(9'h000, 9'h000, 2'b10, 5);
        chk(c_oe | b_oe | b_out, 9'h000);
        chk({c_out_n[7:0], disch}, 9'h1ff);
        chk(xfb, 9'h001);
        rst_n <= 1'b1;
        go(9'h001, 9'h001, 2'b10, 6);
        chk({b_oe, c_oe[0]}, 10'h002);
        go(9'h000, 9'h000, 2'b10, 8);
        repeat (20) begin
            k = $urandom % 8;
            m = bit_of(k == 7 ? 8 : k);
            if ($urandom % 2) begin
                go(m, 9'h000, 2'b10, 6);
                chk(b_oe & b_out, m);
            end else begin
                go(9'h000, m, 2'b10, 6);
                chk(c_oe & ~c_out_n, m);
            end
            go(9'h000, 9'h000, 2'b10, 8);
            chk(c_oe | b_oe, 9'h000);
        end
        for (int i = 0; i < 2; i++) begin
            m = i ? bit_of(4) : 9'h000;
            go(bit_of(2) | m, 9'h000, 2'b10, 15);
            chk({disch, dir}, 9'h000);
            go(bit_of(2) | bit_of(8) | m, bit_of(4) & ~m, 2'b10, 15);
            chk({disch, drive, dir}, 9'h004);
            go(bit_of(2) | m, bit_of(4) & ~m, 2'b10, 15);
            chk({drive, dir}, {1'b1, dir_exp(1'b1, i[0])});
            go(9'h000, 9'h000, 2'b10, 20);
            chk(drive, 9'h000);
        end
        go(bit_of(2), 9'h000, 2'b10, 120);
        chk(disch, 9'h001);
        go(bit_of(1), 9'h000, 2'b11, 6);
        chk({b_oe, c_oe}, 18'h3_fe00);
        go(bit_of(0), 9'h000, 2'b00, 6);
        chk({c_oe | b_oe, drive}, 10'h000);
        go(bit_of(6), 9'h000, 2'b10, 10);
        go(bit_of(6), bit_of(7), 2'b10, 8);
        chk({b_oe, c_oe}, {9'h000, bit_of(7)});
        go(9'h000, 9'h000, 2'b10, 10);
        chk(c_oe | b_oe, 9'h000);
        end_sim();
    end
endmodule
bind scsi_diff_control_converter scsi_conv_checker chk_u (.*);
